// *** hdl/bbcc_top.sv ***
// new master flush handshake, interrupt flush line and swap control
// What this block and the bridge do
// [R1] flush buffers before granting new master
// [R2] request flush: drive low one clock, release
// [R3] bridge seeing low drives low, flushes
// [R4] bridge drives high one clock, then releases
// [R5] grant only after line seen deasserted
// [R6] afterwards drive line deasserted until next winner
// [R7] line synchronous, negated during reset
// [R8] interrupt flush negated until controller ready
// [R9] copy direction high selects copy up
// [R10] copy direction low selects copy down
// [R11] bridge copies lanes per direction
// [R12] output enables only in mismatched cycles
// [R13] enable bits map lanes, bit2 two lanes
// [R14] latch enables mismatched only, not bridge writes
// [R15] four latch bits, one per lane
// [R16] hold request asserted in reset, synchronous
// [R17] release own driver while bridge drives
`timescale 1ns/1ps
`include "bbcc_map.svh"
// usage notes
//   new_master_won may be a pulse or a level: each idle cycle in which it is
//   high starts one handshake, and a high seen while busy queues one more
//   the flush pins are split into in, out and an active low enable for the pad;
//   the enable is high, our driver off, from the cycle after the low pulse
//   until the bridge's high pulse has been seen
//   grant_new_master is a one cycle pulse standing in the cycle after the
//   edge which saw the bridge's high pulse
//   intc_ready is kept inside the block once seen, so a pulse is enough
//   bus_hold_request is high through reset and then copies bus_hold_need
//   the swap controls follow swap_in one cycle later and hold no other state
module bbcc_top (
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  srst,
  // arbitration side
  input  wire logic                  new_master_won,
  input  wire logic                  bus_hold_need,
  input  wire logic                  bus_hold_acknowledge,
  output logic                       grant_new_master,
  output logic                       bus_hold_request,
  output logic                       bus_owned,
  // new master flush pin
  input  wire logic                  new_master_flush_n_in,
  output logic                       new_master_flush_n_out,
  output logic                       new_master_flush_n_oe_n,
  // interrupt controller flush pin
  input  wire logic                  intc_ready,
  input  wire logic                  intc_flush_req,
  input  wire logic                  intc_flush_n_in,
  output logic                       intc_flush_n_out,
  output logic                       intc_flush_n_oe_n,
  output logic                       intc_flush_seen,
  // swap cycle description and bridge controls
  input  wire bbcc_pkg::bbcc_swap_t  swap_in,
  output logic                       copy_direction_up,
  output logic [`BBCC_OE_W-1:0]      swap_out_enable_n,
  output logic [`BBCC_LE_W-1:0]      swap_latch_enable_n
);
  bbcc_pkg::bbcc_state_t state;       // flush handshake state
  bbcc_pkg::bbcc_state_t next_state;  // combinational next state
  logic                  intc_armed;  // set once controller is ready
  logic                  pend;        // winner arrived while busy

  // pin drive decode: the bridge owns the line from our release after the low pulse to its high pulse
  // next_* values are decoded from next_state so the pins change on the same
  // edge as the state, which keeps every pin a plain flip-flop output
  wire logic req_phase   = (state == bbcc_pkg::BBCC_REQ);
  wire logic bridge_own  = (state == bbcc_pkg::BBCC_WAIT_LOW) || (state == bbcc_pkg::BBCC_WAIT_HIGH);
  wire logic flushed     = (state == bbcc_pkg::BBCC_WAIT_HIGH) && new_master_flush_n_in;
  wire logic start_flush = (state == bbcc_pkg::BBCC_IDLE) && (new_master_won || pend);
  wire logic next_oe_n   = bbcc_pkg::bbcc_state_t'(next_state) inside {bbcc_pkg::BBCC_WAIT_LOW,
                                                                        bbcc_pkg::BBCC_WAIT_HIGH};
  wire logic next_nmf    = (next_state != bbcc_pkg::BBCC_REQ);

  // handshake timeline, one clock edge to a line:
  //   e0    winner sampled while idle; line goes low, driven
  //   e1    line released; the bridge is expected to hold it low
  //   en    bridge low sampled; now waiting for its high pulse
  //   em    bridge high sampled; grant rises, line driven high again
  //   em+1  grant falls, back to idle and ready for the next winner
  // limitation: the wait states have no time-out; a bridge that never answers
  // stalls every later grant, which is the safe failure since no new master
  // can then meet stale data in the system buffers
  // a winner that arrives while busy waits in pend and starts right after
  // handshake sequencing; a pulse of exactly one cycle before release
  always_comb begin
    next_state = state;
    case (state)
      bbcc_pkg::BBCC_IDLE:      if (start_flush) next_state = bbcc_pkg::BBCC_REQ;     // [R1]
      bbcc_pkg::BBCC_REQ:       next_state = bbcc_pkg::BBCC_WAIT_LOW;                 // [R2]
      // bridge should pull low at once; we only sample, never drive here
      bbcc_pkg::BBCC_WAIT_LOW:  if (!new_master_flush_n_in) next_state = bbcc_pkg::BBCC_WAIT_HIGH; // [R3]
      bbcc_pkg::BBCC_WAIT_HIGH: if (flushed) next_state = bbcc_pkg::BBCC_GRANT;       // [R4] [R5]
      // grant lasts one state; the default driver role is already back here
      bbcc_pkg::BBCC_GRANT:     next_state = bbcc_pkg::BBCC_IDLE;                     // [R6]
      default:                  next_state = bbcc_pkg::BBCC_IDLE;
    endcase
  end

  // state and pins; reset negates the line and drives it
  // driving high in reset rather than floating keeps the bridge from taking
  // a floating low for a flush request
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state                   <= bbcc_pkg::BBCC_IDLE;
      new_master_flush_n_out  <= 1'b1;  // [R7]
      new_master_flush_n_oe_n <= 1'b0;
      grant_new_master        <= 1'b0;
    end else begin
      state                   <= next_state;
      new_master_flush_n_out  <= next_nmf;   // [R2] [R6]
      new_master_flush_n_oe_n <= next_oe_n;  // [R17]
      grant_new_master        <= (next_state == bbcc_pkg::BBCC_GRANT); // [R5]
    end
  end

  // a winner during a handshake is remembered; set wins over clear
  // a level held on new_master_won therefore queues at most one more flush,
  // which is all the arbiter can ask for while a handshake runs
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pend <= 1'b0;
    end else if (new_master_won && (state != bbcc_pkg::BBCC_IDLE)) begin
      pend <= 1'b1;
    end else if (start_flush) begin
      pend <= 1'b0;
    end
  end

  // hold request asserted in reset, then follows demand
  // these are plain registered copies; arbitration itself lives elsewhere
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      bus_hold_request <= 1'b1;  // [R16]
      bus_owned        <= 1'b0;
    end else begin
      bus_hold_request <= bus_hold_need;
      bus_owned        <= bus_hold_acknowledge;  // [R16]
    end
  end

  // interrupt flush stays negated and driven until the controller is up
  // three line states: driven high before the controller is up, driven low
  // while a flush is asked for, released otherwise so the bridge may pull it
  // low; the seen flag counts only lows met while already released
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      intc_armed        <= 1'b0;
      intc_flush_n_out  <= 1'b1;
      intc_flush_n_oe_n <= 1'b0;
      intc_flush_seen   <= 1'b0;
    end else begin
      if (intc_ready) intc_armed <= 1'b1;
      intc_flush_n_out  <= ~(intc_armed & intc_flush_req);  // [R8]
      // once armed the line is released when idle so the bridge may drive it
      intc_flush_n_oe_n <= intc_armed & ~intc_flush_req;
      intc_flush_seen   <= intc_flush_n_oe_n & ~intc_flush_n_in;  // [R8]
    end
  end

  // swap buffer controls; lane copy itself is the bridge's job
  // the sub-block registers every output, so the swap pins also leave this
  // block straight from flip-flops, one cycle after the cycle description
  bbcc_swap_ctrl u_swap (
    .sys_clk             (sys_clk),
    .srst                (srst),
    .swap_in             (swap_in),  // [R11]
    .copy_direction_up   (copy_direction_up),
    .swap_out_enable_n   (swap_out_enable_n),
    .swap_latch_enable_n (swap_latch_enable_n)
  );

  // flush handshake checks
  req_pulse_a: assert property (@(posedge sys_clk) disable iff (srst)
    $fell(new_master_flush_n_out) |=> new_master_flush_n_out && new_master_flush_n_oe_n) // [R2]
    else $error("flush request not one cycle then release");
  no_drive_a: assert property (@(posedge sys_clk) disable iff (srst)
    bridge_own |-> new_master_flush_n_oe_n) // [R17]
    else $error("driver on while bridge owns line");
  grant_after_a: assert property (@(posedge sys_clk) disable iff (srst)
    grant_new_master |-> $past(new_master_flush_n_in) && $past(state == bbcc_pkg::BBCC_WAIT_HIGH)) // [R5]
    else $error("grant without flush done");
  idle_high_a: assert property (@(posedge sys_clk) disable iff (srst)
    (state == bbcc_pkg::BBCC_IDLE && !start_flush) |=> new_master_flush_n_out && !new_master_flush_n_oe_n) // [R6]
    else $error("line not held deasserted when idle");
  reset_neg_a: assert property (@(posedge sys_clk)
    srst |=> new_master_flush_n_out && bus_hold_request) // [R7] [R16]
    else $error("reset values wrong");
  intc_neg_a: assert property (@(posedge sys_clk) disable iff (srst)
    !intc_armed |=> intc_flush_n_out) // [R8]
    else $error("interrupt flush asserted before ready");
  wait_start_a: assert property (@(posedge sys_clk) disable iff (srst)
    start_flush |=> !new_master_flush_n_out ##1 new_master_flush_n_oe_n) // [R1] [R3]
    else $error("flush start sequence wrong");

  // each of these pins one edge of the handshake timeline, the reset levels or the queued winner
  req_level_a: assert property (@(posedge sys_clk) disable iff (srst)
    req_phase |-> !new_master_flush_n_out && !new_master_flush_n_oe_n) // [R2]
    else $error("request cycle not driven low");
  low_only_req_a: assert property (@(posedge sys_clk) disable iff (srst)
    !new_master_flush_n_out |-> req_phase) // [R2]
    else $error("line low outside request cycle");
  start_req_a: assert property (@(posedge sys_clk) disable iff (srst)
    start_flush |=> req_phase) // [R1]
    else $error("winner did not start a flush");
  wait_low_a: assert property (@(posedge sys_clk) disable iff (srst)
    (state == bbcc_pkg::BBCC_WAIT_LOW && new_master_flush_n_in) |=> (state == bbcc_pkg::BBCC_WAIT_LOW)) // [R3]
    else $error("left wait before bridge low");
  wait_high_entry_a: assert property (@(posedge sys_clk) disable iff (srst)
    (state == bbcc_pkg::BBCC_WAIT_LOW && !new_master_flush_n_in) |=> (state == bbcc_pkg::BBCC_WAIT_HIGH)) // [R3]
    else $error("bridge low not followed");
  wait_high_stay_a: assert property (@(posedge sys_clk) disable iff (srst)
    (state == bbcc_pkg::BBCC_WAIT_HIGH && !new_master_flush_n_in) |=> (state == bbcc_pkg::BBCC_WAIT_HIGH)) // [R5]
    else $error("left wait before bridge high");
  grant_flushed_a: assert property (@(posedge sys_clk) disable iff (srst)
    (state == bbcc_pkg::BBCC_WAIT_HIGH && new_master_flush_n_in) |=> grant_new_master) // [R5]
    else $error("no grant after flush done");
  grant_pulse_a: assert property (@(posedge sys_clk) disable iff (srst)
    grant_new_master |=> !grant_new_master) // [R5]
    else $error("grant longer than one cycle");
  grant_state_a: assert property (@(posedge sys_clk) disable iff (srst)
    grant_new_master |-> (state == bbcc_pkg::BBCC_GRANT)) // [R5]
    else $error("grant outside grant state");
  busy_no_grant_a: assert property (@(posedge sys_clk) disable iff (srst)
    bridge_own |-> !grant_new_master) // [R1]
    else $error("grant while bridge flushes");
  grant_drive_a: assert property (@(posedge sys_clk) disable iff (srst)
    grant_new_master |-> new_master_flush_n_out && !new_master_flush_n_oe_n) // [R6]
    else $error("line not driven high at grant");
  idle_drive_a: assert property (@(posedge sys_clk) disable iff (srst)
    (state == bbcc_pkg::BBCC_IDLE) |-> new_master_flush_n_out && !new_master_flush_n_oe_n) // [R6]
    else $error("line not driven high in idle");
  reset_drive_a: assert property (@(posedge sys_clk)
    srst |=> !new_master_flush_n_oe_n && !grant_new_master) // [R7]
    else $error("line not driven in reset");
  pend_set_a: assert property (@(posedge sys_clk) disable iff (srst)
    (new_master_won && (state != bbcc_pkg::BBCC_IDLE)) |=> pend) // [R1]
    else $error("busy winner lost");
  pend_clear_a: assert property (@(posedge sys_clk) disable iff (srst)
    start_flush |=> !pend) // [R1]
    else $error("queued winner served twice");

  // hold request checks
  hold_follow_a: assert property (@(posedge sys_clk) disable iff (srst)
    1'b1 |=> (bus_hold_request == $past(bus_hold_need))) // [R16]
    else $error("hold request not following demand");
  owned_follow_a: assert property (@(posedge sys_clk) disable iff (srst)
    1'b1 |=> (bus_owned == $past(bus_hold_acknowledge))) // [R16]
    else $error("ownership not following acknowledge");

  // interrupt flush line checks
  intc_reset_a: assert property (@(posedge sys_clk)
    srst |=> intc_flush_n_out && !intc_flush_n_oe_n) // [R8]
    else $error("interrupt flush not negated in reset");
  intc_unarmed_a: assert property (@(posedge sys_clk) disable iff (srst)
    !intc_armed |=> !intc_flush_n_oe_n) // [R8]
    else $error("interrupt flush released before ready");
  intc_sticky_a: assert property (@(posedge sys_clk) disable iff (srst)
    intc_armed |=> intc_armed) // [R8]
    else $error("interrupt flush ready lost");
  intc_low_drv_a: assert property (@(posedge sys_clk) disable iff (srst)
    !intc_flush_n_out |-> !intc_flush_n_oe_n) // [R8]
    else $error("interrupt flush low not driven");
  intc_release_a: assert property (@(posedge sys_clk) disable iff (srst)
    intc_flush_n_oe_n |-> intc_armed) // [R8]
    else $error("interrupt flush released unarmed");
  intc_seen_a: assert property (@(posedge sys_clk) disable iff (srst)
    intc_flush_seen |-> $past(intc_flush_n_oe_n)) // [R8]
    else $error("interrupt flush seen while driving");
  intc_drive_a: assert property (@(posedge sys_clk) disable iff (srst)
    (intc_armed && intc_flush_req) |=> !intc_flush_n_out) // [R8]
    else $error("interrupt flush request not driven");

  // swap controls as seen at the block's pins
  le_idle_a: assert property (@(posedge sys_clk) disable iff (srst)
    !swap_in.mismatch |=> (swap_latch_enable_n == `BBCC_LE_IDLE)) // [R14]
    else $error("latch enable outside mismatch");
  oe_lane0_a: assert property (@(posedge sys_clk) disable iff (srst)
    (swap_in.mismatch && swap_in.byte_en[`BBCC_BE_LANE0]) |=> !swap_out_enable_n[`BBCC_OE_LANE0]) // [R13]
    else $error("lane 0 enable missing");
  oe_lane1_a: assert property (@(posedge sys_clk) disable iff (srst)
    (swap_in.mismatch && swap_in.byte_en[`BBCC_BE_LANE1]) |=> !swap_out_enable_n[`BBCC_OE_LANE1]) // [R13]
    else $error("lane 1 enable missing");
  oe_lane3_a: assert property (@(posedge sys_clk) disable iff (srst)
    (swap_in.mismatch && swap_in.byte_en[`BBCC_BE_LANE3]) |=> !swap_out_enable_n[`BBCC_OE_LANE23]) // [R13]
    else $error("lane 3 enable missing");
  le_lane0_a: assert property (@(posedge sys_clk) disable iff (srst)
    (swap_in.mismatch && !swap_in.bridge_write && swap_in.byte_en[`BBCC_BE_LANE0])
      |=> !swap_latch_enable_n[`BBCC_BE_LANE0]) // [R15]
    else $error("lane 0 latch missing");
  le_lane1_a: assert property (@(posedge sys_clk) disable iff (srst)
    (swap_in.mismatch && !swap_in.bridge_write && swap_in.byte_en[`BBCC_BE_LANE1])
      |=> !swap_latch_enable_n[`BBCC_BE_LANE1]) // [R15]
    else $error("lane 1 latch missing");
  le_lane2_a: assert property (@(posedge sys_clk) disable iff (srst)
    (swap_in.mismatch && !swap_in.bridge_write && swap_in.byte_en[`BBCC_BE_LANE2])
      |=> !swap_latch_enable_n[`BBCC_BE_LANE2]) // [R15]
    else $error("lane 2 latch missing");
  copy_up_a: assert property (@(posedge sys_clk) disable iff (srst)
    swap_in.copy_up |=> copy_direction_up) // [R9]
    else $error("copy up not selected");
  copy_down_a: assert property (@(posedge sys_clk) disable iff (srst)
    !swap_in.copy_up |=> !copy_direction_up) // [R10]
    else $error("copy down not selected");
endmodule

// *** pkg/bbcc_map.svh ***
// constants for the bridge buffer coherency control block
`ifndef BBCC_MAP_SVH
`define BBCC_MAP_SVH
`define BBCC_OE_W        3
`define BBCC_LE_W        4
`define BBCC_OE_IDLE     3'h7
`define BBCC_LE_IDLE     4'hf
`define BBCC_OE_LANE0    0
`define BBCC_OE_LANE1    1
`define BBCC_OE_LANE23   2
`define BBCC_BE_LANE0    0
`define BBCC_BE_LANE1    1
`define BBCC_BE_LANE2    2
`define BBCC_BE_LANE3    3
`define BBCC_CLK_NS      10
`define BBCC_REQ_NS      10
`define BBCC_REQ_CYC     ((`BBCC_REQ_NS + `BBCC_CLK_NS - 1) / `BBCC_CLK_NS)
`endif

// *** pkg/bbcc_pkg.sv ***
// types for the bridge buffer coherency control block
package bbcc_pkg;
  typedef enum logic [2:0] {
    BBCC_IDLE,
    BBCC_REQ,
    BBCC_WAIT_LOW,
    BBCC_WAIT_HIGH,
    BBCC_GRANT
  } bbcc_state_t;

  // one cycle request describing a swap cycle
  typedef struct packed {
    logic       mismatch;
    logic       bridge_write;
    logic       copy_up;
    logic [3:0] byte_en;
  } bbcc_swap_t;

  // pin group for a three-state line
  typedef struct packed {
    logic out_val;
    logic oe_n;
  } bbcc_pin_t;
endpackage

// *** hdl/bbcc_swap_ctrl.sv ***
// swap buffer direction, output enable and latch enable generation
`timescale 1ns/1ps
`include "bbcc_map.svh"
module bbcc_swap_ctrl (
  // clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    srst,
  // cycle description
  input  wire bbcc_pkg::bbcc_swap_t    swap_in,
  // outputs to the bridge
  output logic                         copy_direction_up,
  output logic [`BBCC_OE_W-1:0]        swap_out_enable_n,
  output logic [`BBCC_LE_W-1:0]        swap_latch_enable_n
);
  wire logic [`BBCC_OE_W-1:0] next_oe_n;  // active low lane enables
  wire logic [`BBCC_LE_W-1:0] next_le_n;  // active low latch enables
  wire logic                  le_allowed; // latching permitted this cycle

  // lanes 2 and 3 share one enable, so either byte turns it on
  assign next_oe_n[`BBCC_OE_LANE0]  = ~(swap_in.mismatch & swap_in.byte_en[`BBCC_BE_LANE0]);  // [R12] [R13]
  assign next_oe_n[`BBCC_OE_LANE1]  = ~(swap_in.mismatch & swap_in.byte_en[`BBCC_BE_LANE1]);  // [R13]
  assign next_oe_n[`BBCC_OE_LANE23] = ~(swap_in.mismatch &
                                       (swap_in.byte_en[`BBCC_BE_LANE2] | swap_in.byte_en[`BBCC_BE_LANE3])); // [R13]
  // bridge initiated writes never latch
  assign le_allowed = swap_in.mismatch & ~swap_in.bridge_write;  // [R14]
  assign next_le_n  = ~({`BBCC_LE_W{le_allowed}} & swap_in.byte_en);  // [R15]

  // registered outputs, idle at reset
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      copy_direction_up   <= 1'b0;
      swap_out_enable_n   <= `BBCC_OE_IDLE;
      swap_latch_enable_n <= `BBCC_LE_IDLE;
    end else begin
      copy_direction_up   <= swap_in.copy_up;  // [R9] [R10]
      swap_out_enable_n   <= next_oe_n;
      swap_latch_enable_n <= next_le_n;
    end
  end

  oe_idle_a: assert property (@(posedge sys_clk) disable iff (srst)
    !swap_in.mismatch |=> (swap_out_enable_n == `BBCC_OE_IDLE)) // [R12]
    else $error("output enable active outside mismatch");
  le_write_a: assert property (@(posedge sys_clk) disable iff (srst)
    swap_in.bridge_write |=> (swap_latch_enable_n == `BBCC_LE_IDLE)) // [R14]
    else $error("latch enable active in bridge write");
  le_lane_a: assert property (@(posedge sys_clk) disable iff (srst)
    (swap_in.mismatch && !swap_in.bridge_write && swap_in.byte_en[`BBCC_BE_LANE3])
      |=> !swap_latch_enable_n[`BBCC_BE_LANE3]) // [R15]
    else $error("lane 3 latch missing");
  oe_lane23_a: assert property (@(posedge sys_clk) disable iff (srst)
    (swap_in.mismatch && swap_in.byte_en[`BBCC_BE_LANE2]) |=> !swap_out_enable_n[`BBCC_OE_LANE23]) // [R13]
    else $error("lane 2/3 enable missing");
  copy_dir_a: assert property (@(posedge sys_clk) disable iff (srst)
    1'b1 |=> (copy_direction_up == $past(swap_in.copy_up))) // [R9] [R10]
    else $error("copy direction wrong");
endmodule

// *** test/bbcc_bridge_model.sv ***
// bridge side model answering the new master flush handshake
`timescale 1ns/1ps
module bbcc_bridge_model (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       srst,
  // flush pin level and flush length in low cycles
  input  wire logic       pin,
  input  wire logic [7:0] hold_cyc,
  // our driver on the pin
  output logic            drv_en,
  output logic            drv_val
);
  logic [7:0] cnt; // low cycles still to go
  // answer a low with our own low, then one high clock, then let go
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      drv_en  <= 1'b0;
      drv_val <= 1'b1;
      cnt     <= 8'h00;
    end else if (!drv_en && !pin) begin
      drv_en  <= 1'b1;
      drv_val <= 1'b0;
      cnt     <= hold_cyc;
    end else if (drv_en && !drv_val) begin
      if (cnt <= 8'h01) drv_val <= 1'b1;
      cnt <= cnt - 8'h01;
    end else if (drv_en) begin
      drv_en <= 1'b0; // released after one high clock
    end
  end
endmodule

// *** test/test_bridge_buffer_coherency_ctrl.sv ***
// self-checking bench for the buffer coherency control block
`timescale 1ns/1ps
module test_bridge_buffer_coherency_ctrl;
  logic sys_clk = 0, srst = 1, won = 0, need = 0, ack = 0, rdy = 0, ireq = 0, ifar = 1, nmf_last = 1;
  bbcc_pkg::bbcc_swap_t swp = '0; // swap cycle description
  logic grant, hreq, owned, nmf_out, nmf_oe_n, nmf_pin, i_out, i_oe_n, i_pin, i_seen, cpy, drv_en, drv_val;
  logic [2:0] oe_n;
  logic [3:0] le_n;
  logic [7:0] hold_cyc = 8'h01; // flush length of the model
  int failures = 0, checks_done = 0, cyc = 0;
  // released pin with no driver toggles, so a stale level never passes
  assign nmf_pin = !nmf_oe_n ? nmf_out : (drv_en ? drv_val : ~nmf_last);
  assign i_pin = i_oe_n ? ifar : i_out;
  bbcc_top u_dut (.sys_clk(sys_clk), .srst(srst), .new_master_won(won), .bus_hold_need(need),
    .bus_hold_acknowledge(ack), .grant_new_master(grant), .bus_hold_request(hreq), .bus_owned(owned),
    .new_master_flush_n_in(nmf_pin), .new_master_flush_n_out(nmf_out), .new_master_flush_n_oe_n(nmf_oe_n),
    .intc_ready(rdy), .intc_flush_req(ireq), .intc_flush_n_in(i_pin), .intc_flush_n_out(i_out),
    .intc_flush_n_oe_n(i_oe_n), .intc_flush_seen(i_seen), .swap_in(swp), .copy_direction_up(cpy),
    .swap_out_enable_n(oe_n), .swap_latch_enable_n(le_n));
  bbcc_bridge_model u_bridge (.sys_clk(sys_clk), .srst(srst), .pin(nmf_pin), .hold_cyc(hold_cyc),
    .drv_en(drv_en), .drv_val(drv_val));
  // clock and the cycle ceiling that cuts a hang short
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    nmf_last <= nmf_pin;
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      failures++;
      stop_test();
    end
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // idle levels while reset is held
  task automatic t_reset;
    chk("nmf out", 1, nmf_out);
    chk("nmf oe_n", 0, nmf_oe_n);
    chk("hold req", 1, hreq);
    chk("oe_n", 8'h07, oe_n);
    chk("le_n", 8'h0f, le_n);
    chk("intc out", 1, i_out);
    $display("test reset done");
  endtask
  // one flush handshake with the bridge holding low d cycles
  task automatic t_flush(input logic [7:0] d);
    int n;
    hold_cyc = d;
    won = 1;
    tick(1);
    won = 0;
    chk("req low", 0, nmf_out);
    chk("req drive", 0, nmf_oe_n);
    tick(1);
    chk("req release", 1, nmf_oe_n);
    n = 1;
    while (!grant && n < 40) begin
      chk("early grant", 0, grant);
      tick(1);
      n++;
    end
    chk("grant delay", d + 2, n[7:0]);
    chk("default drv", 0, nmf_oe_n);
    chk("default val", 1, nmf_out);
    tick(3);
    chk("grant pulse", 0, grant);
    chk("idle pin", 1, nmf_pin);
    $display("test flush done");
  endtask
  // a winner held for two cycles queues a second handshake behind the first
  task automatic t_pend;
    int g;
    g = 0;
    hold_cyc = 8'h01;
    won = 1;
    tick(2);
    won = 0;
    repeat (30) begin
      if (grant) g++;
      tick(1);
    end
    chk("queued grants", 2, g[7:0]);
    chk("pend idle pin", 1, nmf_pin);
    $display("test pend done");
  endtask
  // every swap cycle description
  task automatic t_swap;
    logic [3:0] be;
    for (int i = 0; i < 128; i++) begin
      swp = i[6:0];
      be = i[3:0];
      tick(1);
      chk("copy dir", {7'h00, i[4]}, cpy);
      chk("oe_n", i[6] ? {5'h00, ~(be[3] | be[2]), ~be[1], ~be[0]} : 8'h07, oe_n);
      chk("le_n", (i[6] && !i[5]) ? {4'h0, ~be} : 8'h0f, le_n);
    end
    swp = '0;
    $display("test swap done");
  endtask
  // interrupt flush line and hold request
  task automatic t_intc_hold;
    ireq = 1;
    tick(2);
    chk("intc unarmed", 1, i_pin);
    rdy = 1;
    tick(2);
    chk("intc flush", 0, i_pin);
    ireq = 0;
    tick(1);
    chk("intc quiet", 0, i_seen);
    tick(1);
    chk("intc release", 1, i_oe_n);
    ifar = 0;
    tick(2);
    chk("intc seen", 1, i_seen);
    ifar = 1;
    need = 1;
    ack = 1;
    tick(1);
    chk("hold on", 8'h03, {hreq, owned});
    need = 0;
    ack = 0;
    tick(1);
    chk("hold off", 0, {hreq, owned});
    $display("test intc and hold done");
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    tick(6);
    t_reset();
    srst = 0;
    tick(1);
    t_flush(8'h01);
    t_flush(8'h05);
    t_pend();
    t_swap();
    t_intc_hold();
    stop_test();
  end
endmodule
